// ==== bench/cshs_assertions.sv ====
// Checker on the microport and the channel outputs.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cshs_assertions (
	input wire logic                          core_clk,
	input wire logic                          reset,
	input wire logic [cshs_pkg::EXT_AW-1:0]   hostAddr,
	input wire logic [cshs_pkg::DATA_W-1:0]   hostWdata,
	input wire logic                          hostWr,
	input wire logic                          hostRd,
	input wire logic [cshs_pkg::DATA_W-1:0]   devRdata,
	input wire logic                          writeAckStrobe,
	input wire logic [cshs_pkg::NUM_PINS-1:0] syncPin,
	input wire logic [cshs_pkg::NUM_CH-1:0]   chanSleep,
	input wire logic [cshs_pkg::NUM_CH-1:0]   ncoStart,
	input wire logic [cshs_pkg::NUM_CH-1:0]   hopLoad
);
	import cshs_pkg::*;
	// ----------
	// Properties
	// ----------
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (reset);
	AST_ACK_AFTER_WR: assert property (hostWr |=> writeAckStrobe)
		else $error("write not acknowledged");
	AST_ACK_CAUSE: assert property (writeAckStrobe |-> $past(hostWr))
		else $error("acknowledge without write");
	AST_RD_NO_ACK: assert property (hostRd && !hostWr |=> !writeAckStrobe)
		else $error("acknowledge after read");
	AST_RD_HOLD: assert property (!$past(hostRd) |-> $stable(devRdata))
		else $error("read data moved without read");
	AST_RESET_ASLEEP: assert property ($past(reset) |-> chanSleep == 4'hf)
		else $error("channel awake after reset");
	AST_SLEEP_BY_HOST: assert property ($rose(chanSleep[0]) |->
		$past(hostWr, 2) && $past(hostAddr, 2) == EXT_SLEEP)
		else $error("sleep set without host write");
	AST_START_AWAKE: assert property (ncoStart[0] |-> !chanSleep[0])
		else $error("start while asleep");
	AST_START_SPACED: assert property (ncoStart[0] |=> !ncoStart[0] [*4])
		else $error("start repeated too soon");
	// Main scenarios reached
	cover property (ncoStart[0]);
	cover property (hopLoad[0]);
	cover property ($rose(syncPin[2]));
	cover property (hostWr && hostAddr == EXT_SOFT_SYNC && hostWdata[SOFT_START_BIT]);
endmodule // cshs_assertions
`default_nettype wire

// ==== bench/tb.sv ====
// Bench joining host and device through the microport interface.
// Assumes the host command port is the only stimulus path.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cshs_pkg::*;
	// ----------
	// Signals
	// ----------
	logic                    core_clk = 1'b0;
	logic                    reset    = 1'b1;
	logic [HOST_AW-1:0]      cmdAddr  = '0;
	logic [DATA_W-1:0]       cmdWdata = '0;
	logic                    cmdWr    = 1'b0;
	logic                    cmdRd    = 1'b0;
	logic [DATA_W-1:0]       cmdRdata;
	logic [NUM_CH-1:0]       chanSleep;
	logic [NUM_CH-1:0]       ncoStart;
	logic [NUM_CH-1:0]       hopLoad;
	logic [NUM_CH-1:0][15:0] ncoFreq;
	logic                    portAOn;
	logic                    portBOn;
	logic                    portAChanMode;
	logic                    portBChanMode;
	logic                    pclkMaster;
	logic [1:0]              pclkDivSel;
	int                      errCount  = 0;
	int                      numChecks = 0;
	int                      cyc       = 0;
	always #25 core_clk = ~core_clk;
	cshs_if busIf ();
	cshs_device i_cshs_device (.core_clk, .reset, .bus(busIf), .chanSleep, .ncoStart,
		.hopLoad, .ncoFreq, .portAOn, .portBOn, .portAChanMode, .portBChanMode,
		.pclkMaster, .pclkDivSel);
	cshs_host i_cshs_host (.core_clk, .reset, .bus(busIf), .cmdAddr, .cmdWdata,
		.cmdWr, .cmdRd, .cmdRdata);
	cshs_assertions i_cshs_assertions (.core_clk, .reset, .hostAddr(busIf.hostAddr),
		.hostWdata(busIf.hostWdata), .hostWr(busIf.hostWr), .hostRd(busIf.hostRd),
		.devRdata(busIf.devRdata), .writeAckStrobe(busIf.writeAckStrobe),
		.syncPin(busIf.syncPin), .chanSleep, .ncoStart, .hopLoad);
	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
		numChecks++;
		if (got !== exp)
		begin
			errCount++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cmdAddr  <= a;
		cmdWdata <= d;
		cmdWr    <= 1'b1;
		@(posedge core_clk);
		cmdWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		cmdAddr <= a;
		cmdRd   <= 1'b1;
		@(posedge core_clk);
		cmdRd <= 1'b0;
		#1 d = cmdRdata;
	endtask
	// Low byte is staged, high byte commits
	task automatic wr_int(input logic [7:0] ptr, input logic [15:0] v);
		wr(4'h6, ptr);
		wr(4'h0, v[7:0]);
		wr(4'h1, v[15:8]);
	endtask
	// Cycles from ack or pin rise to the start or load pulse
	task automatic lat(input bit pin, input int p, input bit hop, input int ch, input int exp);
		int n;
		n = 0;
		#1;
		repeat (50)
		begin
			if (pin ? busIf.syncPin[p] : busIf.writeAckStrobe)
				break;
			@(posedge core_clk);
			#1;
		end
		repeat (300)
		begin
			@(posedge core_clk);
			#1;
			n++;
			if (hop ? hopLoad[ch] : ncoStart[ch])
				break;
		end
		check(16'(n), 16'(exp), "latency");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------
	// Scenarios
	// ----------
	// Second trigger lands mid-count and must not restart it
	task automatic t_soft_start();
		wr(4'h3, 8'h0f);
		wr_int(8'h83, 16'h0005);
		wr(4'h5, 8'h11);
		wr(4'h5, 8'h11);
		lat(0, 0, 0, 0, 9);
		check(16'(chanSleep), 16'h000e, "soft wake");
		$display("test soft start done");
	endtask
	task automatic t_pin_start();
		wr(4'h3, 8'h0f);
		// Sleep write reaches the pins two clocks after the command
		repeat (2) @(posedge core_clk);
		#1 check(16'(chanSleep), 16'h000f, "sleep write");
		wr(4'h7, 8'h08);
		wr(4'h4, 8'h14);
		wr(4'h9, 8'h04);
		lat(1, 2, 0, 1, 8);
		check(16'(chanSleep), 16'h000d, "pin wake");
		wr(4'h9, 8'h00);
		$display("test pin start done");
	endtask
	task automatic t_soft_hop();
		wr_int(8'h84, 16'h0004);
		wr_int(8'h85, 16'h1234);
		wr(4'h5, 8'h01);
		wr(4'h4, 8'h40);
		lat(0, 0, 1, 0, 11);
		// Frequency register follows the load pulse by one clock
		@(posedge core_clk);
		#1 check(ncoFreq[0], 16'h1234, "soft hop freq");
		$display("test soft hop done");
	endtask
	task automatic t_pin_hop();
		wr_int(8'h84, 16'h0003);
		for (int p = 0; p < 4; p++)
		begin
			wr_int(8'h85, 16'h1000 + 16'(p));
			wr(4'h7, 8'(p));
			wr(4'h4, 8'h20 | (8'h01 << p));
			check(ncoFreq[0], (p == 0) ? 16'h1234 : 16'h0fff + 16'(p), "shadow");
			wr(4'h9, 8'h01 << p);
			lat(1, p, 1, 0, 8);
			@(posedge core_clk);
			#1 check(ncoFreq[0], 16'h1000 + 16'(p), "pin hop freq");
			wr(4'h9, 8'h00);
		end
		wr_int(8'h84, 16'h0000);
		wr_int(8'h85, 16'hbeef);
		repeat (2) @(posedge core_clk);
		#1 check(ncoFreq[3], 16'hbeef, "no hold freq");
		$display("test hop done");
	endtask
	task automatic t_ports();
		logic [7:0] d;
		wr(4'hb, 8'h03);
		wr(4'h3, 8'h0f);
		wr_int(8'h1b, 16'h0081);
		rd(4'hb, d);
		check(16'({d[0], portAOn}), 16'h0002, "locked port");
		wr(4'hb, 8'h03);
		wr(4'h3, 8'h2f);
		wr_int(8'h1d, 16'h0040);
		wr_int(8'h1b, 16'h0081);
		wr_int(8'h1e, 16'h0005);
		rd(4'hb, d);
		check(16'(d[0]), 16'h0000, "legal pairing");
		check(16'({portAOn, portAChanMode, portBOn, portBChanMode, pclkMaster, pclkDivSel}),
			16'h0066, "port config");
		// Microport read of the open clock register through the pointer
		wr(4'h8, 8'h00);
		@(posedge core_clk);
		rd(4'ha, d);
		check(16'(d), 16'h0005, "port readback");
		wr_int(8'h1d, 16'h00c0);
		rd(4'hb, d);
		check(16'({d[0], portBOn}), 16'h0002, "bad pairing");
		$display("test ports done");
	endtask
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			errCount++;
			summarize();
		end
	end
	initial
	begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1 check(16'(chanSleep), 16'h000f, "reset sleep");
		check(16'({portAOn, portBOn}), 16'h0000, "reset ports");
		$display("test reset done");
		t_soft_start();
		t_pin_start();
		t_soft_hop();
		t_pin_hop();
		t_ports();
		summarize();
	end
endmodule // tb
`default_nettype wire

// ==== core/cshs_device.sv ====
// Device end: register file, hold-off counters, port enables.
// Assumes microport strobes synchronous to core_clk, one cycle long.
//
// Function
// - Start and hop each use shadow plus counter; start here has counter only
// - Counter armed by soft sync or pin
// - Reset puts all four channels asleep
// - Host may sleep any channel anytime; a same-cycle start fire wins here
// - Unsynced start: sleep, load, hold one, wake
// - Host programs sync hold-off within 2..fffe
// - Soft start counts down, wakes at one
// - Soft start runs hold plus six after ack
// - Each channel picks any one sync pin
// - Host sets start-on-pin and pin enable
// - Pin start counts, runs hold plus three
// - Zero hop hold applies frequency at once
// - Soft hop counts down, loads at one
// - Soft hop runs hold plus seven after ack
// - Pin hop runs hold plus five after rise
// - Two sixteen-bit parallel ports, shared pins
// - Only port A/link B or B/A together
// - Port registers reachable only with access bit
// - Link control bit seven enables each port
// - Each port in channel or AGC mode
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// One hold-off counter with its latency taps
// -------------------------------------------------------------------
module cshs_holdoff #(
	parameter int SOFT_TAP = 4,
	parameter int PIN_TAP  = 0
) (
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	input  wire logic                      trigSoft,
	input  wire logic                      trigPin,
	input  wire logic [cshs_pkg::HOLD_W-1:0] holdVal,
	output logic                           fire,
	output logic                           done
);
	import cshs_pkg::*;
	logic              pendQ;
	logic              activeQ;
	logic              srcPinQ;
	logic [HOLD_W-1:0] cntQ;
	logic [PIPE_W-1:0] softPipeQ;
	logic [PIPE_W-1:0] pinPipeQ;
	logic              busy;
	logic              trig;

	assign busy = pendQ | activeQ;
	assign trig = (trigSoft | trigPin) & ~busy;
	assign fire = activeQ && (cntQ <= 16'h0001);

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pendQ   <= 1'b0;
			activeQ <= 1'b0;
			srcPinQ <= 1'b0;
			cntQ    <= '0;
		end
		else
		begin
			pendQ <= trig;
			if (trig)
				srcPinQ <= ~trigSoft;
			if (pendQ)
			begin
				cntQ    <= holdVal;
				activeQ <= 1'b1;
			end
			else if (fire)
				activeQ <= 1'b0;
			else if (activeQ)
				cntQ <= cntQ - 16'h0001;
		end
	end

	// Separate taps: soft and pin paths differ in fixed latency
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			softPipeQ <= '0;
			pinPipeQ  <= '0;
			done      <= 1'b0;
		end
		else
		begin
			softPipeQ <= {softPipeQ[PIPE_W-2:0], fire & ~srcPinQ};
			pinPipeQ  <= {pinPipeQ[PIPE_W-2:0], fire & srcPinQ};
			done      <= softPipeQ[SOFT_TAP] | pinPipeQ[PIN_TAP];
		end
	end
endmodule // cshs_holdoff

// -------------------------------------------------------------------
// Device top
// -------------------------------------------------------------------
module cshs_device (
	input  wire logic                                 core_clk,
	input  wire logic                                 reset,
	cshs_if.device                                    bus,
	output logic [cshs_pkg::NUM_CH-1:0]               chanSleep,
	output logic [cshs_pkg::NUM_CH-1:0]               ncoStart,
	output logic [cshs_pkg::NUM_CH-1:0]               hopLoad,
	output logic [cshs_pkg::NUM_CH-1:0][15:0]         ncoFreq,
	output logic                                      portAOn,
	output logic                                      portBOn,
	output logic                                      portAChanMode,
	output logic                                      portBChanMode,
	output logic                                      pclkMaster,
	output logic [1:0]                                pclkDivSel
);
	import cshs_pkg::*;
	logic [7:0]          sleepQ, sleepD;
	logic [7:0]          pinCtlQ, softCtlQ, ptrQ, dataLoQ, pinSelQ;
	logic [7:0]          portCfgAQ, linkCfgAQ, portCfgBQ, linkCfgBQ, pclkCfgQ;
	logic [HOLD_W-1:0]   startHoldQ, hopHoldQ, freqShadowQ;
	logic [NUM_PINS-1:0] pinPrevQ, pinEdge;
	logic [DATA_W-1:0]   rdataQ, rdNext;
	logic                ackQ;
	logic [15:0]         intRd, intWdata;
	logic                intWr, portOpen, portSpace, softStart, softHop;
	logic [NUM_CH-1:0]   startFire, startDone, hopDone;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	assign intWdata  = {bus.hostWdata, dataLoQ};
	assign intWr     = bus.hostWr && (bus.hostAddr == EXT_DATA_HI);
	assign portOpen  = sleepQ[ACCESS_PORT_BIT];
	assign portSpace = (ptrQ >= INT_PORT_A) && (ptrQ <= INT_PCLK);
	assign softStart = bus.hostWr && (bus.hostAddr == EXT_SOFT_SYNC)
		&& bus.hostWdata[SOFT_START_BIT];
	assign softHop   = bus.hostWr && (bus.hostAddr == EXT_PIN_SYNC)
		&& bus.hostWdata[SOFT_HOP_BIT];
	assign pinEdge   = bus.syncPin & ~pinPrevQ;
	// Hardware wake wins over a same-cycle software write
	assign sleepD    = (bus.hostWr && bus.hostAddr == EXT_SLEEP) ? bus.hostWdata : sleepQ;

	always_comb
	begin
		intRd = 16'h0000;
		case (ptrQ)
			INT_PORT_A:     intRd = portOpen ? {8'h00, portCfgAQ} : 16'h0000;
			INT_LINK_A:     intRd = portOpen ? {8'h00, linkCfgAQ} : 16'h0000;
			INT_PORT_B:     intRd = portOpen ? {8'h00, portCfgBQ} : 16'h0000;
			INT_LINK_B:     intRd = portOpen ? {8'h00, linkCfgBQ} : 16'h0000;
			INT_PCLK:       intRd = portOpen ? {8'h00, pclkCfgQ} : 16'h0000;
			INT_START_HOLD: intRd = startHoldQ;
			INT_HOP_HOLD:   intRd = hopHoldQ;
			INT_NCO_FREQ:   intRd = freqShadowQ;
			default:        intRd = 16'h0000;
		endcase
	end

	always_comb
	begin
		rdNext = 8'h00;
		case (bus.hostAddr)
			EXT_DATA_LO:   rdNext = intRd[7:0];
			EXT_DATA_HI:   rdNext = intRd[15:8];
			EXT_SLEEP:     rdNext = sleepQ;
			EXT_PIN_SYNC:  rdNext = pinCtlQ;
			EXT_SOFT_SYNC: rdNext = softCtlQ;
			EXT_POINTER:   rdNext = ptrQ;
			EXT_PIN_SEL:   rdNext = pinSelQ;
			default:       rdNext = 8'h00;
		endcase
	end

	assign bus.devRdata       = rdataQ;
	assign bus.writeAckStrobe = ackQ;

	// ---------------------------------------------------------------
	// Direct registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sleepQ   <= SLEEP_RESET;
			pinCtlQ  <= 8'h00;
			softCtlQ <= 8'h00;
			ptrQ     <= 8'h00;
			dataLoQ  <= 8'h00;
			pinSelQ  <= 8'h00;
			pinPrevQ <= '0;
			rdataQ   <= 8'h00;
			ackQ     <= 1'b0;
		end
		else
		begin
			sleepQ   <= sleepD & ~{4'h0, startFire};
			pinPrevQ <= bus.syncPin;
			ackQ     <= bus.hostWr;
			if (bus.hostRd)
				rdataQ <= rdNext;
			if (bus.hostWr)
			begin
				case (bus.hostAddr)
					EXT_DATA_LO:   dataLoQ  <= bus.hostWdata;
					EXT_PIN_SYNC:  pinCtlQ  <= bus.hostWdata;
					EXT_SOFT_SYNC: softCtlQ <= bus.hostWdata;
					EXT_POINTER:   ptrQ     <= bus.hostWdata;
					EXT_PIN_SEL:   pinSelQ  <= bus.hostWdata;
					default:       ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Indirect registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			portCfgAQ   <= 8'h00;
			linkCfgAQ   <= 8'h00;
			portCfgBQ   <= 8'h00;
			linkCfgBQ   <= 8'h00;
			pclkCfgQ    <= 8'h00;
			startHoldQ  <= '0;
			hopHoldQ    <= '0;
			freqShadowQ <= '0;
		end
		else if (intWr && (!portSpace || portOpen))
		begin
			case (ptrQ)
				INT_PORT_A:     portCfgAQ   <= intWdata[7:0];
				INT_LINK_A:     linkCfgAQ   <= intWdata[7:0];
				INT_PORT_B:     portCfgBQ   <= intWdata[7:0];
				INT_LINK_B:     linkCfgBQ   <= intWdata[7:0];
				INT_PCLK:       pclkCfgQ    <= intWdata[7:0];
				INT_START_HOLD: startHoldQ  <= intWdata;
				INT_HOP_HOLD:   hopHoldQ    <= intWdata;
				INT_NCO_FREQ:   freqShadowQ <= intWdata;
				default:        ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Per-channel start and hop
	// ---------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : gCh
		logic [1:0] sel;
		logic       pinHit;
		assign sel    = pinSelQ[2*ch +: 2];
		assign pinHit = pinEdge[sel] & pinCtlQ[sel];

		cshs_holdoff #(
			.SOFT_TAP (START_SOFT_LAT - SOFT_TAP_OFFSET),
			.PIN_TAP  (START_PIN_LAT - PIN_TAP_OFFSET)
		) uStart (
			.core_clk (core_clk),
			.reset    (reset),
			.trigSoft (softStart & bus.hostWdata[ch]),
			.trigPin  (pinHit & pinCtlQ[PIN_START_BIT]),
			.holdVal  (startHoldQ),
			.fire     (startFire[ch]),
			.done     (startDone[ch])
		);

		cshs_holdoff #(
			.SOFT_TAP (HOP_SOFT_LAT - SOFT_TAP_OFFSET),
			.PIN_TAP  (HOP_PIN_LAT - PIN_TAP_OFFSET)
		) uHop (
			.core_clk (core_clk),
			.reset    (reset),
			.trigSoft (softHop & softCtlQ[ch]),
			.trigPin  (pinHit & pinCtlQ[PIN_HOP_BIT]),
			.holdVal  (hopHoldQ),
			.fire     (),
			.done     (hopDone[ch])
		);

		always_ff @(posedge core_clk)
		begin
			if (reset)
				ncoFreq[ch] <= 16'h0000;
			else if (intWr && ptrQ == INT_NCO_FREQ && hopHoldQ == 16'h0000)
				ncoFreq[ch] <= intWdata;
			else if (hopDone[ch])
				ncoFreq[ch] <= freqShadowQ;
		end
	end

	assign ncoStart = startDone;
	assign hopLoad  = hopDone;

	// ---------------------------------------------------------------
	// Output port routing
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			chanSleep     <= SLEEP_RESET[3:0];
			portAOn       <= 1'b0;
			portBOn       <= 1'b0;
			portAChanMode <= 1'b0;
			portBChanMode <= 1'b0;
			pclkMaster    <= 1'b0;
			pclkDivSel    <= 2'b00;
		end
		else
		begin
			chanSleep     <= sleepQ[3:0];
			// A port sharing its path with an active link stays off
			portAOn       <= linkCfgAQ[PAR_EN_BIT] & ~linkCfgAQ[LINK_EN_BIT];
			portBOn       <= linkCfgBQ[PAR_EN_BIT] & ~linkCfgBQ[LINK_EN_BIT]
				& ~linkCfgAQ[PAR_EN_BIT];
			portAChanMode <= linkCfgAQ[CHAN_MODE_BIT];
			portBChanMode <= linkCfgBQ[CHAN_MODE_BIT];
			pclkMaster    <= pclkCfgQ[PCLK_MASTER_BIT];
			pclkDivSel    <= pclkCfgQ[PCLK_DIV_LSB +: 2];
		end
	end
endmodule // cshs_device
`default_nettype wire

// ==== core/cshs_host.sv ====
// Host end: forwards microport writes, screens illegal sequences.
// Assumes the command port master runs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cshs_host (
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	cshs_if.host                               bus,
	input  wire logic [cshs_pkg::HOST_AW-1:0]  cmdAddr,
	input  wire logic [cshs_pkg::DATA_W-1:0]   cmdWdata,
	input  wire logic                          cmdWr,
	input  wire logic                          cmdRd,
	output logic [cshs_pkg::DATA_W-1:0]        cmdRdata
);
	import cshs_pkg::*;
	logic [EXT_AW-1:0] addrQ;
	logic [7:0]        wdataQ, sleepCopyQ, ptrCopyQ, loCopyQ, linkACopyQ, linkBCopyQ;
	logic [7:0]        rdCapQ, statusQ;
	logic [15:0]       startHoldQ, hopHoldQ, commit;
	logic [3:0]        pinsQ;
	logic              wrQ, rdQ, rdPendQ;
	logic              extWr, okStart, okHop, badSoft, badPin, badPort, badPair, refuse;
	logic              pa, la, pb, lb;

	// ---------------------------------------------------------------
	// Screening
	// ---------------------------------------------------------------
	assign extWr   = cmdWr && (cmdAddr <= HOST_EXT_TOP);
	assign commit  = {cmdWdata, loCopyQ};
	assign okStart = (startHoldQ >= HOLD_MIN_SYNC) && (startHoldQ <= HOLD_MAX_SYNC);
	assign okHop   = (hopHoldQ >= HOLD_MIN_SYNC) && (hopHoldQ <= HOLD_MAX_SYNC);
	assign badSoft = ((cmdAddr[2:0] == EXT_SOFT_SYNC) && cmdWdata[SOFT_START_BIT] && !okStart)
		|| ((cmdAddr[2:0] == EXT_PIN_SYNC) && cmdWdata[SOFT_HOP_BIT] && !okHop);
	assign badPin  = (cmdAddr[2:0] == EXT_PIN_SYNC)
		&& ((cmdWdata[PIN_START_BIT] && !okStart) || (cmdWdata[PIN_HOP_BIT] && !okHop));
	assign badPort = (cmdAddr[2:0] == EXT_DATA_HI) && (ptrCopyQ >= INT_PORT_A)
		&& (ptrCopyQ <= INT_PCLK) && !sleepCopyQ[ACCESS_PORT_BIT];
	assign pa = (ptrCopyQ == INT_LINK_A) ? commit[PAR_EN_BIT] : linkACopyQ[PAR_EN_BIT];
	assign la = (ptrCopyQ == INT_LINK_A) ? commit[LINK_EN_BIT] : linkACopyQ[LINK_EN_BIT];
	assign pb = (ptrCopyQ == INT_LINK_B) ? commit[PAR_EN_BIT] : linkBCopyQ[PAR_EN_BIT];
	assign lb = (ptrCopyQ == INT_LINK_B) ? commit[LINK_EN_BIT] : linkBCopyQ[LINK_EN_BIT];
	assign badPair = (cmdAddr[2:0] == EXT_DATA_HI)
		&& ((pa & la) | (pb & lb) | (pa & pb) | (la & lb));
	assign refuse  = extWr && (badSoft || badPin || badPort || badPair);

	assign bus.hostAddr  = addrQ;
	assign bus.hostWdata = wdataQ;
	assign bus.hostWr    = wrQ;
	assign bus.hostRd    = rdQ;
	assign bus.syncPin   = pinsQ;

	// ---------------------------------------------------------------
	// Microport drive and shadow copies
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			addrQ <= '0;
			wdataQ <= 8'h00;
			wrQ <= 1'b0;
			rdQ <= 1'b0;
			rdPendQ <= 1'b0;
			sleepCopyQ <= SLEEP_RESET;
			ptrCopyQ <= 8'h00;
			loCopyQ <= 8'h00;
			linkACopyQ <= 8'h00;
			linkBCopyQ <= 8'h00;
			startHoldQ <= '0;
			hopHoldQ <= '0;
		end
		else
		begin
			wrQ <= extWr && !refuse;
			rdQ <= cmdWr && (cmdAddr == HOST_RD_CMD);
			rdPendQ <= rdQ;
			if (extWr && !refuse)
			begin
				addrQ  <= cmdAddr[2:0];
				wdataQ <= cmdWdata;
				case (cmdAddr[2:0])
					EXT_SLEEP:   sleepCopyQ <= cmdWdata;
					EXT_POINTER: ptrCopyQ <= cmdWdata;
					EXT_DATA_LO: loCopyQ <= cmdWdata;
					EXT_DATA_HI:
					begin
						if (ptrCopyQ == INT_LINK_A)
							linkACopyQ <= commit[7:0];
						if (ptrCopyQ == INT_LINK_B)
							linkBCopyQ <= commit[7:0];
						if (ptrCopyQ == INT_START_HOLD)
							startHoldQ <= commit;
						if (ptrCopyQ == INT_HOP_HOLD)
							hopHoldQ <= commit;
					end
					default: ;
				endcase
			end
			else if (cmdWr && cmdAddr == HOST_RD_CMD)
				addrQ <= cmdWdata[2:0];
		end
	end

	// ---------------------------------------------------------------
	// Command port registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pinsQ <= 4'h0;
			rdCapQ <= 8'h00;
			statusQ <= 8'h00;
			cmdRdata <= 8'h00;
		end
		else
		begin
			if (cmdWr && cmdAddr == HOST_PINS)
				pinsQ <= cmdWdata[3:0];
			if (rdPendQ)
				rdCapQ <= bus.devRdata;
			// Set wins over a same-cycle clear
			statusQ[STAT_REFUSED_BIT] <= refuse
				| (statusQ[STAT_REFUSED_BIT]
				& ~(cmdWr && cmdAddr == HOST_STATUS && cmdWdata[STAT_REFUSED_BIT]));
			statusQ[STAT_ACK_BIT] <= bus.writeAckStrobe
				| (statusQ[STAT_ACK_BIT]
				& ~(cmdWr && cmdAddr == HOST_STATUS && cmdWdata[STAT_ACK_BIT]));
			if (cmdRd)
			begin
				case (cmdAddr)
					HOST_PINS:    cmdRdata <= {4'h0, pinsQ};
					HOST_RD_DATA: cmdRdata <= rdCapQ;
					HOST_STATUS:  cmdRdata <= statusQ;
					default:      cmdRdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // cshs_host
`default_nettype wire

// ==== core/cshs_if.sv ====
// Microport and sync pins between host and device.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface cshs_if;
	import cshs_pkg::*;
	logic [EXT_AW-1:0]   hostAddr;
	logic [DATA_W-1:0]   hostWdata;
	logic                hostWr;
	logic                hostRd;
	logic [DATA_W-1:0]   devRdata;
	logic                writeAckStrobe;
	logic [NUM_PINS-1:0] syncPin;
	modport device (input hostAddr, hostWdata, hostWr, hostRd, syncPin,
		output devRdata, writeAckStrobe);
	modport host (output hostAddr, hostWdata, hostWr, hostRd, syncPin,
		input devRdata, writeAckStrobe);
endinterface
`default_nettype wire

// ==== core/cshs_pkg.sv ====
// Shared constants for channel start and hop synchronisation.
// Assumes one core clock; the microport is eight bits wide.
package cshs_pkg;
	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int EXT_AW   = 3;
	localparam int DATA_W   = 8;
	localparam int HOLD_W   = 16;
	localparam int NUM_CH   = 4;
	localparam int NUM_PINS = 4;
	localparam int PIPE_W   = 6;
	localparam int HOST_AW  = 4;
	// ---------------------------------------------------------------
	// External (direct) addresses
	// ---------------------------------------------------------------
	localparam logic [2:0] EXT_DATA_LO   = 3'h0;
	localparam logic [2:0] EXT_DATA_HI   = 3'h1;
	localparam logic [2:0] EXT_SLEEP     = 3'h3;
	localparam logic [2:0] EXT_PIN_SYNC  = 3'h4;
	localparam logic [2:0] EXT_SOFT_SYNC = 3'h5;
	localparam logic [2:0] EXT_POINTER   = 3'h6;
	localparam logic [2:0] EXT_PIN_SEL   = 3'h7;
	// ---------------------------------------------------------------
	// Internal (indirect) addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] INT_PORT_A     = 8'h1a;
	localparam logic [7:0] INT_LINK_A     = 8'h1b;
	localparam logic [7:0] INT_PORT_B     = 8'h1c;
	localparam logic [7:0] INT_LINK_B     = 8'h1d;
	localparam logic [7:0] INT_PCLK       = 8'h1e;
	localparam logic [7:0] INT_START_HOLD = 8'h83;
	localparam logic [7:0] INT_HOP_HOLD   = 8'h84;
	localparam logic [7:0] INT_NCO_FREQ   = 8'h85;
	// ---------------------------------------------------------------
	// Fields and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] SLEEP_RESET    = 8'h0f;
	localparam int ACCESS_PORT_BIT = 5;
	localparam int PIN_START_BIT   = 4;
	localparam int PIN_HOP_BIT     = 5;
	localparam int SOFT_HOP_BIT    = 6;
	localparam int SOFT_START_BIT  = 4;
	localparam int PAR_EN_BIT      = 7;
	localparam int LINK_EN_BIT     = 6;
	localparam int CHAN_MODE_BIT   = 0;
	localparam int PCLK_MASTER_BIT = 0;
	localparam int PCLK_DIV_LSB    = 1;
	localparam logic [15:0] HOLD_MIN_SYNC = 16'h0002;
	localparam logic [15:0] HOLD_MAX_SYNC = 16'hfffe;
	// ---------------------------------------------------------------
	// Latencies, trigger to action, in core clocks
	// ---------------------------------------------------------------
	localparam int START_SOFT_LAT  = 6;
	localparam int START_PIN_LAT   = 3;
	localparam int HOP_SOFT_LAT    = 7;
	localparam int HOP_PIN_LAT     = 5;
	localparam int SOFT_TAP_OFFSET = 2;
	localparam int PIN_TAP_OFFSET  = 3;
	// ---------------------------------------------------------------
	// Host command port map
	// ---------------------------------------------------------------
	localparam logic [3:0] HOST_EXT_TOP = 4'h7;
	localparam logic [3:0] HOST_RD_CMD  = 4'h8;
	localparam logic [3:0] HOST_PINS    = 4'h9;
	localparam logic [3:0] HOST_RD_DATA = 4'ha;
	localparam logic [3:0] HOST_STATUS  = 4'hb;
	localparam int STAT_REFUSED_BIT = 0;
	localparam int STAT_ACK_BIT     = 1;
endpackage
